// file: hw/cmpc_top.sv
// comparator channel control register, input routing and event logic
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "cmpc_regs.svh"
module cmpc_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // analog core control
    output logic core_enable,
    output logic positive_input_select,
    output cmpc_pkg::cmpc_nsel_t negative_input_select,
    input wire logic core_result,
    // output pin
    output logic result_output_pin_o,
    output logic result_output_pin_oe_n,
    // event
    output logic cmp_event
);
    import cmpc_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] rdata_q;
    logic raw_sync;
    logic level_q;
    logic pin_q;
    logic pin_oe_n_q;
    logic hit;
    cmpc_evt_if evt ();

    function automatic logic [31:0] cmpc_merge(input logic [31:0] old, input logic [31:0] wd);
        cmpc_merge = (old & ~`CMPC_WRITE_MASK) | (wd & `CMPC_WRITE_MASK);
    endfunction

    assign hit = (reg_addr == `CMPC_CTRL_ADDR);

    // fields are written together; enable changes nothing else
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= `CMPC_RESET_VALUE;
        end else if (reg_wr && hit) begin
            ctrl_q <= cmpc_merge(ctrl_q, reg_wdata);
        end
    end

    cmpc_sync u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(core_result),
        .sync_out(raw_sync)
    );

    // an off channel reports a steady low rather than a floating core
    always_ff @(posedge clk) begin
        if (srst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= ctrl_q[`CMPC_BIT_ENABLE] & (raw_sync ^ ctrl_q[`CMPC_BIT_INVERT]);
        end
    end

    assign evt.level = level_q;
    assign evt.edge_sel = cmpc_edge_t'(ctrl_q[`CMPC_EDGE_HI:`CMPC_EDGE_LO]);

    cmpc_edge u_edge (
        .clk(clk),
        .srst(srst),
        .evt(evt)
    );
    assign cmp_event = evt.pulse;

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_q <= level_q;
            pin_oe_n_q <= ~ctrl_q[`CMPC_BIT_DRIVE];
        end
    end
    assign result_output_pin_o = pin_q;
    assign result_output_pin_oe_n = pin_oe_n_q;

    assign core_enable = ctrl_q[`CMPC_BIT_ENABLE];
    assign positive_input_select = ctrl_q[`CMPC_BIT_PSEL];
    assign negative_input_select = cmpc_nsel_t'(ctrl_q[`CMPC_NSEL_HI:`CMPC_NSEL_LO]);

    // unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd && hit) begin
            rdata_q <= ctrl_q | ({31'h0000_0000, level_q} << `CMPC_BIT_STATUS);
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_q;

    property p_wr_mask;
        @(posedge clk) disable iff (srst)
        reg_wr && hit |=> (ctrl_q & ~`CMPC_WRITE_MASK) == 32'h0000_0000;
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("reserved bit stored");

    property p_enable_keeps;
        @(posedge clk) disable iff (srst)
        reg_wr && hit |=> ctrl_q[`CMPC_BIT_ENABLE] == $past(reg_wdata[`CMPC_BIT_ENABLE]);
    endproperty
    a_enable_keeps: assert property (p_enable_keeps) else $error("enable not taken");

    property p_drive;
        @(posedge clk) disable iff (srst)
        ctrl_q[`CMPC_BIT_DRIVE] ##1 ctrl_q[`CMPC_BIT_DRIVE] |-> !result_output_pin_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("pin not driven");

    property p_invert;
        @(posedge clk) disable iff (srst)
        ctrl_q[`CMPC_BIT_ENABLE] |=> level_q == ($past(raw_sync) ^ $past(ctrl_q[`CMPC_BIT_INVERT]));
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong");

    property p_status;
        @(posedge clk) disable iff (srst)
        reg_rd && hit |=> reg_rdata[`CMPC_BIT_STATUS] == $past(level_q);
    endproperty
    a_status: assert property (p_status) else $error("status bit wrong");

    property p_rise;
        @(posedge clk) disable iff (srst)
        $rose(level_q) && ctrl_q[`CMPC_EDGE_LO] && $stable(ctrl_q) |=> cmp_event;
    endproperty
    a_rise: assert property (p_rise) else $error("rising event missed");

    property p_fall;
        @(posedge clk) disable iff (srst)
        $fell(level_q) && ctrl_q[`CMPC_EDGE_HI] && $stable(ctrl_q) |=> cmp_event;
    endproperty
    a_fall: assert property (p_fall) else $error("falling event missed");

    property p_none;
        @(posedge clk) disable iff (srst)
        $past(ctrl_q[`CMPC_EDGE_HI:`CMPC_EDGE_LO]) == 2'h0 |-> !cmp_event;
    endproperty
    a_none: assert property (p_none) else $error("event while disabled");

    property p_single;
        @(posedge clk) disable iff (srst)
        cmp_event |=> !cmp_event;
    endproperty
    a_single: assert property (p_single) else $error("event longer than a cycle");

    property p_select;
        @(posedge clk) disable iff (srst)
        reg_wr && hit |=> negative_input_select == cmpc_nsel_t'($past(reg_wdata[1:0]));
    endproperty
    a_select: assert property (p_select) else $error("negative select wrong");

    property p_psel;
        @(posedge clk) disable iff (srst)
        reg_wr && hit |=> positive_input_select == $past(reg_wdata[`CMPC_BIT_PSEL]);
    endproperty
    a_psel: assert property (p_psel) else $error("positive select wrong");

    // an off channel must not leave a stale level behind for the edge logic
    property p_disabled_low;
        @(posedge clk) disable iff (srst)
        !ctrl_q[`CMPC_BIT_ENABLE] |=> !level_q;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("level high while off");

    property p_pin_data;
        @(posedge clk) disable iff (srst)
        1'b1 |=> result_output_pin_o == $past(level_q);
    endproperty
    a_pin_data: assert property (p_pin_data) else $error("pin data not processed level");

    property p_pin_release;
        @(posedge clk) disable iff (srst)
        !ctrl_q[`CMPC_BIT_DRIVE] |=> result_output_pin_oe_n;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin driven while off");

    property p_rdata_idle;
        @(posedge clk) disable iff (srst)
        !(reg_rd && hit) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

    property p_rdata_reserved;
        @(posedge clk) disable iff (srst)
        reg_rd && hit |=> (reg_rdata & ~(`CMPC_WRITE_MASK | 32'h0000_0100)) == 32'h0000_0000;
    endproperty
    a_rdata_reserved: assert property (p_rdata_reserved) else $error("reserved bit read");

    property p_both;
        @(posedge clk) disable iff (srst)
        $changed(level_q) && ctrl_q[`CMPC_EDGE_HI:`CMPC_EDGE_LO] == 2'h3 |=> cmp_event;
    endproperty
    a_both: assert property (p_both) else $error("edge event missed");

    property p_rise_only;
        @(posedge clk) disable iff (srst)
        $past(ctrl_q[`CMPC_EDGE_HI:`CMPC_EDGE_LO]) == 2'h1 && cmp_event |-> $past(level_q);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("event on falling edge");

    property p_fall_only;
        @(posedge clk) disable iff (srst)
        $past(ctrl_q[`CMPC_EDGE_HI:`CMPC_EDGE_LO]) == 2'h2 && cmp_event |-> !$past(level_q);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("event on rising edge");

    // a pulse needs a level change one cycle before it, never a held level
    property p_pulse_edge;
        @(posedge clk) disable iff (srst)
        cmp_event |-> $past(level_q) != $past(level_q, 2);
    endproperty
    a_pulse_edge: assert property (p_pulse_edge) else $error("event without edge");

    c_rise: cover property (@(posedge clk) disable iff (srst) cmp_event && level_q);
    c_fall: cover property (@(posedge clk) disable iff (srst) cmp_event && !level_q);
    c_inv: cover property (@(posedge clk) disable iff (srst)
        ctrl_q[`CMPC_BIT_INVERT] && cmp_event);
    c_read: cover property (@(posedge clk) disable iff (srst)
        reg_rd && hit ##1 reg_rdata[`CMPC_BIT_STATUS]);
endmodule

// file: hw/cmpc_regs.svh
// register offsets, field positions and reset values of the comparator control block
// Functional notes
// - enable bit 15 turns channel on/off; other fields stay untouched
// - drive enable bit 14 puts result on output pin, else pin released
// - invert bit 13 flips comparator output before any use
// - status bit 8 reads current result, one when high
// - edge select 11 raises an event on rising and falling edges
// - edge select 10 raises an event only on falling edges
// - edge select 01 raises an event only on rising edges
// - edge select 00 raises no event at all
// - positive select bit 4: one picks ladder reference, zero picks pin A
// - negative select 1-0: 00 B, 01 C, 10 D, 11 fixed reference
// - inversion also feeds event logic, so edges swap meaning
// - unimplemented bits, including 31-26 and 12-9, read zero, ignore writes
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH
`define CMPC_CTRL_ADDR 4'h0
`define CMPC_BIT_ENABLE 15
`define CMPC_BIT_DRIVE 14
`define CMPC_BIT_INVERT 13
`define CMPC_BIT_STATUS 8
`define CMPC_EDGE_HI 7
`define CMPC_EDGE_LO 6
`define CMPC_BIT_PSEL 4
`define CMPC_NSEL_HI 1
`define CMPC_NSEL_LO 0
`define CMPC_WRITE_MASK 32'h0000_E0D3
`define CMPC_RESET_VALUE 32'h0000_00C3
`endif

// file: hw/cmpc_pkg.sv
// types shared by the comparator control block
package cmpc_pkg;
    typedef enum logic [1:0] {
        CMPC_EDGE_NONE = 2'h0,
        CMPC_EDGE_RISE = 2'h1,
        CMPC_EDGE_FALL = 2'h2,
        CMPC_EDGE_BOTH = 2'h3
    } cmpc_edge_t;
    typedef enum logic [1:0] {
        CMPC_NEG_PIN_B = 2'h0,
        CMPC_NEG_PIN_C = 2'h1,
        CMPC_NEG_PIN_D = 2'h2,
        CMPC_NEG_FIXED = 2'h3
    } cmpc_nsel_t;
endpackage

// file: hw/cmpc_evt_if.sv
// synchronised result and event settings between control and edge logic
`timescale 1ns/100ps
interface cmpc_evt_if;
    import cmpc_pkg::*;
    logic level;
    cmpc_edge_t edge_sel;
    logic pulse;
    modport ctrl (output level, output edge_sel, input pulse);
    modport det (input level, input edge_sel, output pulse);
endinterface

// file: hw/cmpc_sync.sv
// two-flop synchroniser for the asynchronous comparator result
`timescale 1ns/100ps
module cmpc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // levels
    input wire logic async_in,
    output logic sync_out
);
    import cmpc_pkg::*;
    logic meta_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: hw/cmpc_edge.sv
// edge detection and event qualification
`timescale 1ns/100ps
module cmpc_edge (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // event carrier
    cmpc_evt_if.det evt
);
    import cmpc_pkg::*;
    logic prev_q;
    logic pulse_q;
    logic rise;
    logic fall;
    assign rise = evt.level & ~prev_q;
    assign fall = ~evt.level & prev_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= evt.level;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            pulse_q <= 1'b0;
        end else begin
            unique case (evt.edge_sel)
                CMPC_EDGE_BOTH: pulse_q <= rise | fall;
                CMPC_EDGE_FALL: pulse_q <= fall;
                CMPC_EDGE_RISE: pulse_q <= rise;
                CMPC_EDGE_NONE: pulse_q <= 1'b0;
            endcase
        end
    end
    assign evt.pulse = pulse_q;
endmodule

// file: sim/cmpc_core_model.sv
// behavioural analog comparator core with its selectable inputs
`timescale 1ns/100ps
module cmpc_core_model #(
    parameter logic [7:0] LADDER_LVL = 8'h10,
    parameter logic [7:0] FIXED_LVL = 8'h40
) (
    // control from the block
    input wire logic core_enable,
    input wire logic positive_input_select,
    input wire cmpc_pkg::cmpc_nsel_t negative_input_select,
    // pin levels
    input wire logic [7:0] lvl_a,
    input wire logic [7:0] lvl_b,
    input wire logic [7:0] lvl_c,
    input wire logic [7:0] lvl_d,
    // raw result
    output logic core_result
);
    import cmpc_pkg::*;
    logic [7:0] pos;
    logic [7:0] neg;
    always_comb begin
        pos = positive_input_select ? LADDER_LVL : lvl_a;
        case (negative_input_select)
            CMPC_NEG_PIN_B: neg = lvl_b;
            CMPC_NEG_PIN_C: neg = lvl_c;
            CMPC_NEG_PIN_D: neg = lvl_d;
            default: neg = FIXED_LVL;
        endcase
        // a switched-off core draws nothing and holds its output low
        core_result = core_enable && (pos > neg);
    end
endmodule

// file: sim/tb_top.sv
// register-level testbench of the comparator control block
`timescale 1ns/100ps
module tb_top;
    import cmpc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic core_enable, positive_input_select, core_result, pin_o, pin_oe_n, cmp_event;
    cmpc_nsel_t negative_input_select;
    logic [7:0] lvl_a = 8'h00;
    int failures = 0;
    int n_tests = 0;
    int n;
    logic [31:0] v;
    wire out_pin = pin_oe_n ? 1'bz : pin_o;
    always #4 clk = ~clk;
    cmpc_top uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_enable(core_enable),
        .positive_input_select(positive_input_select),
        .negative_input_select(negative_input_select), .core_result(core_result),
        .result_output_pin_o(pin_o), .result_output_pin_oe_n(pin_oe_n), .cmp_event(cmp_event));
    cmpc_core_model core (.core_enable(core_enable), .positive_input_select(positive_input_select),
        .negative_input_select(negative_input_select), .lvl_a(lvl_a), .lvl_b(8'h20),
        .lvl_c(8'h60), .lvl_d(8'h08), .core_result(core_result));
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask
    task edge_cnt(input logic [7:0] lvl);
        @(posedge clk);
        lvl_a <= lvl;
        n = 0;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (cmp_event === 1'b1) n++;
        end
    endtask
    task test_done;
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(4'h0, 32'h0000_00C3);
        chk("nsel_reset", 32'h3, {30'h0, negative_input_select});
        wr(4'h1, 32'hFFFF_FFFF);
        rd(4'h1, 32'h0);
        rd(4'h0, 32'h0000_00C3);
        wr(4'h0, 32'hFFFF_1F2C);
        rd(4'h0, 32'h0);
        chk("core_off", 32'h0, {31'h0, core_enable});
        lvl_a <= 8'h50;
        // selection table: bit index is the negative select code
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                v = 32'h8000 | (p << 4) | s;
                wr(4'h0, v);
                chk("core_enable", 32'h1, {31'h0, core_enable});
                chk("psel", p, {31'h0, positive_input_select});
                chk("nsel", s, {30'h0, negative_input_select});
                rd(4'h0, v | ((p ? 4'b0100 : 4'b1101) >> s & 1) << 8);
            end
        end
        wr(4'h0, 32'hA000);
        rd(4'h0, 32'hA000);
        wr(4'h0, 32'hC000);
        chk("pin_on", 32'h1, {31'h0, out_pin});
        wr(4'h0, 32'hE000);
        chk("pin_inv", 32'h0, {31'h0, out_pin});
        wr(4'h0, 32'h8000);
        chk("pin_off", 32'h1, {31'h0, pin_oe_n});
        for (int i = 0; i < 2; i++) begin
            for (int e = 0; e < 4; e++) begin
                lvl_a <= 8'h00;
                wr(4'h0, 32'h8000 | (i << 13) | (e << 6));
                edge_cnt(8'h50);
                chk("event_rise", i ? e[1] : e[0], n);
                edge_cnt(8'h00);
                chk("event_fall", i ? e[0] : e[1], n);
            end
        end
        // reset in mid-run must bring back the power-on control word
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(4'h0, 32'h0000_00C3);
        chk("oe_n_reset", 32'h1, {31'h0, pin_oe_n});
        test_done();
    end
endmodule
